/* rtl/pirm_defs.svh */
// Offsets, field positions, reset values and selector codes of the peripheral input remap block
`ifndef PIRM_DEFS_SVH
`define PIRM_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define PIRM_SPI2_MAP_OFS 8'h00
`define PIRM_CAN_MAP_OFS 8'h04
`define PIRM_DTC_MAP_OFS 8'h08

// Selector field width and positions
`define PIRM_SEL_W 7
`define PIRM_SEL_LO_LSB 0
`define PIRM_SEL_HI_LSB 8

// Reset value of every selector field
`define PIRM_SEL_RST 7'h00

// Selector codes with a fixed meaning
`define PIRM_CODE_VSS 7'h00
`define PIRM_CODE_COMPARATOR_ONE_OUTPUT 7'h01
`define PIRM_CODE_PIN121 7'h79

// Number of routed peripheral inputs and of selectable sources
`define PIRM_NUM_ROUTES 4
`define PIRM_NUM_SRC 128

// Routed input index
`define PIRM_IDX_SPI2 0
`define PIRM_IDX_CAN 1
`define PIRM_IDX_DTC2 2
`define PIRM_IDX_DTC3 3

// AXI response codes
`define PIRM_RESP_OKAY 2'h0
`define PIRM_RESP_DECERR 2'h3

`endif

/* rtl/pirm_pkg.sv */
// Types shared by the peripheral input remap block
`include "pirm_defs.svh"
package pirm_pkg;
    typedef logic [`PIRM_SEL_W-1:0] pirm_sel_t;
    typedef logic [`PIRM_NUM_SRC-1:0] pirm_src_t;

    // Whole state of the remap top
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pirm_sel_t spi_sel;
        pirm_sel_t can_sel;
        pirm_sel_t dtc2_sel;
        pirm_sel_t dtc3_sel;
        logic [`PIRM_NUM_ROUTES-1:0] route;
    } pirm_state_t;
endpackage : pirm_pkg

/* rtl/pirm_source_mux.sv */
// One selector-driven source multiplexer for a remapped peripheral input
`timescale 1ns/1ps
`include "pirm_defs.svh"
module pirm_source_mux (
    input wire pirm_pkg::pirm_src_t src,
    input wire pirm_pkg::pirm_sel_t sel,
    output logic routed,
    output logic code_valid
);
    import pirm_pkg::*;

    // Source vector index equals the selector code; codes past pin 121 see a zero
    always_comb begin
        routed = src[sel];
        code_valid = (sel <= `PIRM_CODE_PIN121);
    end
endmodule : pirm_source_mux

/* rtl/pirm_remap.sv */
// Peripheral input remap: selector registers on AXI4-Lite and the routed peripheral inputs
//
// Operation
// (R1) SPI2 slave select input follows the source picked by spi2 map bits 6-0.
// (R2) CAN receive input follows the source picked by can map bits 6-0.
// (R3) Dead-time map: bits 14-8 pick compensation input 3, bits 6-0 input 2.
// (R4) Selector code 1111001 connects the input to remappable pin 121.
// (R5) Selector code 0000001 connects the input to comparator one output.
// (R6) Selector code 0000000 holds the input low.
// (R7) Bits above each selector field ignore writes and read as zero.
// (R8) Reset clears every selector, so all routed inputs sit low.
`timescale 1ns/1ps
`include "pirm_defs.svh"
module pirm_remap (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [121:2] remappable_pin,
    input wire logic comparator_one_output,
    output logic spi2_slave_select_input,
    output logic can_receive_input,
    output logic deadtime_comp_in2_input,
    output logic deadtime_comp_in3_input,
    output logic [`PIRM_NUM_ROUTES-1:0] route_code_valid
);
    import pirm_pkg::*;

    pirm_state_t st_q;
    pirm_state_t st_d;
    pirm_src_t src_vec;
    pirm_sel_t sel_vec [`PIRM_NUM_ROUTES];
    logic [`PIRM_NUM_ROUTES-1:0] mux_out;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;

    // Source vector: code 0 ground, code 1 comparator, codes 2..121 the pins, above reads low
    assign src_vec = {6'h00, remappable_pin, comparator_one_output, 1'b0}; // [R4] [R5] [R6]

    // Selector of each routed input
    assign sel_vec[`PIRM_IDX_SPI2] = st_q.spi_sel; // [R1]
    assign sel_vec[`PIRM_IDX_CAN] = st_q.can_sel; // [R2]
    assign sel_vec[`PIRM_IDX_DTC2] = st_q.dtc2_sel; // [R3]
    assign sel_vec[`PIRM_IDX_DTC3] = st_q.dtc3_sel; // [R3]

    // One multiplexer per routed input
    genvar gi;
    generate
        for (gi = 0; gi < `PIRM_NUM_ROUTES; gi++) begin : g_route
            pirm_source_mux u_mux (
                .src(src_vec),
                .sel(sel_vec[gi]),
                .routed(mux_out[gi]),
                .code_valid(route_code_valid[gi])
            );
        end
    endgenerate

    // Word-aligned addresses for decode
    assign wr_addr = {st_q.aw_addr[7:2], 2'b00};
    assign rd_addr = {s_axi_araddr[7:2], 2'b00};

    // Read value of a register, unimplemented bits as zero
    function automatic logic [31:0] pirm_read(input logic [7:0] addr, input pirm_state_t s);
        logic [31:0] val;
        val = 32'h0000_0000;
        case (addr)
            `PIRM_SPI2_MAP_OFS: val = {25'h0000000, s.spi_sel}; // [R7]
            `PIRM_CAN_MAP_OFS: val = {25'h0000000, s.can_sel}; // [R7]
            `PIRM_DTC_MAP_OFS: val = {17'h00000, s.dtc3_sel, 1'b0, s.dtc2_sel}; // [R7]
            default: val = 32'h0000_0000;
        endcase
        return val;
    endfunction : pirm_read

    // Next-state logic: bus slave, selector writes and routed input capture
    always_comb begin
        st_d = st_q;
        // Address and data channels are taken independently
        if (s_axi_awvalid && !st_q.aw_held) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_held) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        // Response handed over
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Perform the write once both halves are held and no response is pending
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `PIRM_RESP_OKAY;
            case (wr_addr)
                `PIRM_SPI2_MAP_OFS: begin
                    if (st_q.w_strb[0]) begin
                        st_d.spi_sel = st_q.w_data[`PIRM_SEL_LO_LSB +: `PIRM_SEL_W]; // [R1] [R7]
                    end
                end
                `PIRM_CAN_MAP_OFS: begin
                    if (st_q.w_strb[0]) begin
                        st_d.can_sel = st_q.w_data[`PIRM_SEL_LO_LSB +: `PIRM_SEL_W]; // [R2] [R7]
                    end
                end
                `PIRM_DTC_MAP_OFS: begin
                    if (st_q.w_strb[0]) begin
                        st_d.dtc2_sel = st_q.w_data[`PIRM_SEL_LO_LSB +: `PIRM_SEL_W]; // [R3]
                    end
                    if (st_q.w_strb[1]) begin
                        st_d.dtc3_sel = st_q.w_data[`PIRM_SEL_HI_LSB +: `PIRM_SEL_W]; // [R3]
                    end
                end
                default: begin
                    st_d.bresp = `PIRM_RESP_DECERR;
                end
            endcase
        end
        // Read channel: one read in flight, answered the cycle after it is taken
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = pirm_read(rd_addr, st_q);
            case (rd_addr)
                `PIRM_SPI2_MAP_OFS, `PIRM_CAN_MAP_OFS, `PIRM_DTC_MAP_OFS: st_d.rresp = `PIRM_RESP_OKAY;
                default: st_d.rresp = `PIRM_RESP_DECERR;
            endcase
        end
        // Routed inputs are registered copies of the multiplexer outputs
        st_d.route = mux_out; // [R1] [R2] [R3]
    end

    // State register; reset clears selectors so every routed input is low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0; // [R8]
        end else begin
            st_q <= st_d;
        end
    end

    // Bus handshake outputs
    assign s_axi_awready = !st_q.aw_held;
    assign s_axi_wready = !st_q.w_held;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    // Routed peripheral inputs
    assign spi2_slave_select_input = st_q.route[`PIRM_IDX_SPI2];
    assign can_receive_input = st_q.route[`PIRM_IDX_CAN];
    assign deadtime_comp_in2_input = st_q.route[`PIRM_IDX_DTC2];
    assign deadtime_comp_in3_input = st_q.route[`PIRM_IDX_DTC3];

    // Checks on routing, register map and reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    spi_route_a: assert property (1'b1 |=> spi2_slave_select_input == $past(src_vec[st_q.spi_sel])) // [R1]
        else $error("spi2 select input does not follow its selector");

    can_route_a: assert property (1'b1 |=> can_receive_input == $past(src_vec[st_q.can_sel])) // [R2]
        else $error("can receive input does not follow its selector");

    dtc_route_a: assert property (1'b1 |=> (deadtime_comp_in3_input == $past(src_vec[st_q.dtc3_sel])) // [R3]
        && (deadtime_comp_in2_input == $past(src_vec[st_q.dtc2_sel])))
        else $error("dead-time compensation input does not follow its selector");

    dtc_field_a: assert property (st_q.aw_held && st_q.w_held && !st_q.bvalid && wr_addr == `PIRM_DTC_MAP_OFS // [R3]
        && st_q.w_strb[1] |=> st_q.dtc3_sel == $past(st_q.w_data[14:8]))
        else $error("bits 14-8 did not load compensation input 3 selector");

    pin_top_a: assert property (st_q.spi_sel == `PIRM_CODE_PIN121 && $stable(st_q.spi_sel) // [R4]
        |=> spi2_slave_select_input == $past(remappable_pin[121]))
        else $error("code 1111001 does not route pin 121");

    comp_sel_a: assert property (st_q.can_sel == `PIRM_CODE_COMPARATOR_ONE_OUTPUT // [R5]
        |=> can_receive_input == $past(comparator_one_output))
        else $error("code 0000001 does not route the comparator");

    ground_sel_a: assert property (st_q.dtc2_sel == `PIRM_CODE_VSS |=> !deadtime_comp_in2_input) // [R6]
        else $error("code 0000000 does not hold the input low");

    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h00000 // [R7]
        && s_axi_rdata[7] == 1'b0)
        else $error("unimplemented register bits read non-zero");

    reset_clear_a: assert property ($fell(sys_rst) |-> st_q.spi_sel == `PIRM_SEL_RST // [R8]
        && st_q.can_sel == `PIRM_SEL_RST && st_q.dtc2_sel == `PIRM_SEL_RST
        && st_q.dtc3_sel == `PIRM_SEL_RST && st_q.route == 4'h0)
        else $error("selectors not cleared by reset");

    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |=> ##1 s_axi_bvalid)
        else $error("write response not given two cycles after both halves");

    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not given one cycle after address");

    // Write performed in this cycle, used by the checks below
    logic wr_fire;
    assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;

    // Bus handshakes close and the slave is free again
    write_done_a: assert property (wr_fire |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write did not raise its response and free both channels");

    bresp_taken_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stayed after it was taken");

    rdata_taken_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data stayed after it was taken");

    bad_write_a: assert property (wr_fire && wr_addr != `PIRM_SPI2_MAP_OFS && wr_addr != `PIRM_CAN_MAP_OFS
        && wr_addr != `PIRM_DTC_MAP_OFS |=> s_axi_bresp == `PIRM_RESP_DECERR && $stable(st_q.spi_sel)
        && $stable(st_q.can_sel) && $stable(st_q.dtc2_sel) && $stable(st_q.dtc3_sel))
        else $error("unmapped write changed a selector or answered okay");

    // Selectors change only through a write to their own field
    sel_hold_a: assert property (!wr_fire |=> $stable(st_q.spi_sel) && $stable(st_q.can_sel) // [R1] [R2] [R3]
        && $stable(st_q.dtc2_sel) && $stable(st_q.dtc3_sel))
        else $error("a selector changed without a write");

    spi_field_a: assert property (wr_fire && wr_addr == `PIRM_SPI2_MAP_OFS && st_q.w_strb[0] // [R1] [R7]
        |=> st_q.spi_sel == $past(st_q.w_data[6:0]) && $stable(st_q.can_sel) && $stable(st_q.dtc2_sel))
        else $error("spi2 map write did not load bits 6-0 alone");

    can_field_a: assert property (wr_fire && wr_addr == `PIRM_CAN_MAP_OFS && st_q.w_strb[0] // [R2] [R7]
        |=> st_q.can_sel == $past(st_q.w_data[6:0]) && $stable(st_q.spi_sel) && $stable(st_q.dtc2_sel))
        else $error("can map write did not load bits 6-0 alone");

    dtc2_field_a: assert property (wr_fire && wr_addr == `PIRM_DTC_MAP_OFS && st_q.w_strb[0] // [R3]
        |=> st_q.dtc2_sel == $past(st_q.w_data[6:0]) && $stable(st_q.spi_sel) && $stable(st_q.can_sel))
        else $error("bits 6-0 did not load compensation input 2 selector");

    // Special codes hold the routed input low
    ground_spi_a: assert property (st_q.spi_sel == `PIRM_CODE_VSS |=> !spi2_slave_select_input) // [R6]
        else $error("code 0000000 does not hold spi2 select low");

    ground_can_a: assert property (st_q.can_sel == `PIRM_CODE_VSS |=> !can_receive_input) // [R6]
        else $error("code 0000000 does not hold can receive low");

    ground_dtc3_a: assert property (st_q.dtc3_sel == `PIRM_CODE_VSS |=> !deadtime_comp_in3_input) // [R6]
        else $error("code 0000000 does not hold compensation input 3 low");

    high_code_a: assert property (st_q.can_sel > `PIRM_CODE_PIN121 // [R4]
        |-> !route_code_valid[`PIRM_IDX_CAN] ##1 !can_receive_input)
        else $error("a code past pin 121 is flagged valid or routes a level");

    // Register readback matches the selectors at the cycle the address is taken
    spi_read_a: assert property (s_axi_arvalid && s_axi_arready && rd_addr == `PIRM_SPI2_MAP_OFS // [R1] [R7]
        |=> s_axi_rdata == {25'h0, $past(st_q.spi_sel)} && s_axi_rresp == `PIRM_RESP_OKAY)
        else $error("spi2 map reads back wrong");

    can_read_a: assert property (s_axi_arvalid && s_axi_arready && rd_addr == `PIRM_CAN_MAP_OFS // [R2] [R7]
        |=> s_axi_rdata == {25'h0, $past(st_q.can_sel)} && s_axi_rresp == `PIRM_RESP_OKAY)
        else $error("can map reads back wrong");

    dtc_read_a: assert property (s_axi_arvalid && s_axi_arready && rd_addr == `PIRM_DTC_MAP_OFS // [R3] [R7]
        |=> s_axi_rdata == {17'h0, $past(st_q.dtc3_sel), 1'b0, $past(st_q.dtc2_sel)})
        else $error("dead-time map reads back wrong");

    single_upper_a: assert property (s_axi_arvalid && s_axi_arready && rd_addr != `PIRM_DTC_MAP_OFS // [R7]
        |=> s_axi_rdata[15:7] == 9'h000)
        else $error("bits 15-7 of a single-selector register read non-zero");

    bad_read_a: assert property (s_axi_arvalid && s_axi_arready && rd_addr != `PIRM_SPI2_MAP_OFS
        && rd_addr != `PIRM_CAN_MAP_OFS && rd_addr != `PIRM_DTC_MAP_OFS
        |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `PIRM_RESP_DECERR)
        else $error("unmapped read did not answer zero with a decode error");

    // Main scenarios
    pin_route_c: cover property (st_q.spi_sel == `PIRM_CODE_PIN121 ##1 spi2_slave_select_input);
    comp_route_c: cover property (st_q.can_sel == `PIRM_CODE_COMPARATOR_ONE_OUTPUT ##1 can_receive_input);
    dtc_write_c: cover property (s_axi_bvalid && st_q.dtc3_sel != `PIRM_SEL_RST);
    bad_addr_c: cover property (s_axi_rvalid && s_axi_rresp == `PIRM_RESP_DECERR);
    bad_write_c: cover property (s_axi_bvalid && s_axi_bresp == `PIRM_RESP_DECERR);
endmodule : pirm_remap

/* sim/tb_top.sv */
// Self-checking testbench of the peripheral input remap block
`timescale 1ns/1ps
`include "pirm_defs.svh"
module tb_top;
    import pirm_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [121:2] pins = {120{1'b1}};
    logic cmp = 1'b1;
    logic spi_o, can_o, dt2_o, dt3_o;
    logic [3:0] code_ok;
    int errors = 0;
    int checks = 0;
    logic [1:0] rsp;
    logic [31:0] rd;

    pirm_remap dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .remappable_pin(pins), .comparator_one_output(cmp), .spi2_slave_select_input(spi_o),
        .can_receive_input(can_o), .deadtime_comp_in2_input(dt2_o), .deadtime_comp_in3_input(dt3_o),
        .route_code_valid(code_ok));

    // Free-running system clock
    always #10 mclk = ~mclk;

    // Verdict and end of run
    task close_out;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // A bounded wait ran out
    task hang;
        errors++;
        $display("unexpected at %0t: bus wait ran out", $time);
        close_out;
    endtask : hang

    // Compare a seen value with the expected one
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Write one word; address and data offered together, held until each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic aw_ok, w_ok, ta, tw, got;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        got = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64 && !(aw_ok && w_ok); n++) begin
            #1;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge mclk);
            if (ta) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (tw) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        for (n = 0; n < 64 && !got; n++) begin
            #1;
            got = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge mclk);
        end
        if (!got) hang;
        s_axi_bready <= 1'b0;
    endtask : wr

    // Read one word; rready held until the answer is sampled
    task automatic rd_w(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ta, got;
        ta = 1'b0;
        got = 1'b0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64 && !got; n++) begin
            #1;
            ta = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        if (!got) hang;
        s_axi_rready <= 1'b0;
    endtask : rd_w

    // Let pin changes and selector updates reach the registered outputs
    task settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    // Cleared selectors hold every input low although all sources are high
    task reset_state;
        int i;
        settle;
        chk({dt3_o, dt2_o, can_o, spi_o}, 4'h0);
        chk(code_ok, 4'hF);
        for (i = 0; i < 3; i++) begin
            rd_w(8'(i * 4), rd, rsp);
            chk(rd, 32'h0);
        end
    endtask : reset_state

    // Highest pin code picks pin 121; upper bits ignore writes
    task spi2_route;
        wr(`PIRM_SPI2_MAP_OFS, 32'hFFFFFFF9, rsp);
        chk(rsp, 2'h0);
        rd_w(`PIRM_SPI2_MAP_OFS, rd, rsp);
        chk(rd, 32'h79);
        settle;
        chk({dt3_o, dt2_o, can_o, spi_o}, 4'h1);
        @(posedge mclk);
        pins[121] <= 1'b0;
        settle;
        chk(spi_o, 1'b0);
    endtask : spi2_route

    // Code one follows the comparator output
    task can_route;
        wr(`PIRM_CAN_MAP_OFS, 32'h00000001, rsp);
        settle;
        chk(can_o, 1'b1);
        @(posedge mclk);
        cmp <= 1'b0;
        settle;
        chk(can_o, 1'b0);
    endtask : can_route

    // Two selectors in one register, each driving its own input
    task dtc_route;
        @(posedge mclk);
        pins <= 120'h8; // Only pin 5 high
        wr(`PIRM_DTC_MAP_OFS, 32'hFFFF8589, rsp);
        rd_w(`PIRM_DTC_MAP_OFS, rd, rsp);
        chk(rd, 32'h0509);
        settle;
        chk({dt3_o, dt2_o, can_o, spi_o}, 4'h8);
        @(posedge mclk);
        pins <= 120'h80; // Only pin 9 high
        settle;
        chk({dt3_o, dt2_o, can_o, spi_o}, 4'h4);
    endtask : dtc_route

    // Code zero ties low; a code past pin 121 is flagged and routes low
    task low_codes;
        wr(`PIRM_DTC_MAP_OFS, 32'h0, rsp);
        wr(`PIRM_SPI2_MAP_OFS, 32'h0, rsp);
        wr(`PIRM_CAN_MAP_OFS, 32'h7A, rsp);
        @(posedge mclk);
        pins <= {120{1'b1}};
        cmp <= 1'b1;
        settle;
        chk({dt3_o, dt2_o, can_o, spi_o}, 4'h0);
        chk(code_ok, 4'hD);
    endtask : low_codes

    // Unmapped offset answers a decode error and stores nothing
    task unmapped;
        wr(8'h0C, 32'h7F, rsp);
        chk(rsp, 2'h3);
        rd_w(8'h0C, rd, rsp);
        chk(rd, 32'h0);
        chk(rsp, 2'h3);
        rd_w(`PIRM_CAN_MAP_OFS, rd, rsp);
        chk(rd, 32'h7A);
    endtask : unmapped

    // A second reset in mid-run clears every selector again
    task mid_reset;
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        settle;
        chk({dt3_o, dt2_o, can_o, spi_o}, 4'h0);
        chk(code_ok, 4'hF);
        rd_w(`PIRM_CAN_MAP_OFS, rd, rsp);
        chk(rd, 32'h0);
    endtask : mid_reset

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        reset_state;
        spi2_route;
        can_route;
        dtc_route;
        low_codes;
        unmapped;
        mid_reset;
        close_out;
    end
endmodule : tb_top
